// ===== rtl/gssr_pkg.sv
// Package with register layouts, bit positions and command codes for the status and service request block.
package gssr_pkg;
  // Status summary byte bit positions.
  localparam int STB_RQS_BIT  = 6;
  localparam int STB_ESB_BIT  = 5;
  // Event status register bit positions.
  localparam int ESR_PON_BIT  = 7;
  localparam int ESR_CME_BIT  = 5;
  localparam int ESR_EXE_BIT  = 4;
  // Bits that are implemented in each register; all others read as zero.
  localparam logic [7:0] ESR_USED_MASK = 8'hB0;
  localparam logic [7:0] SRE_USED_MASK = 8'h20;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  // Reset values of the enable masks.
  localparam logic [7:0] SRE_RESET     = 8'h00;
  localparam logic [7:0] ESE_RESET     = 8'h00;
  // Interface function subset levels advertised to the controller.
  localparam logic [3:0] SUBSET_SH     = 4'h1;
  localparam logic [3:0] SUBSET_AH     = 4'h1;
  localparam logic [3:0] SUBSET_T      = 4'h6;
  localparam logic [3:0] SUBSET_L      = 4'h4;
  localparam logic [3:0] SUBSET_SR     = 4'h1;
  localparam logic [3:0] SUBSET_RL     = 4'h1;
  localparam logic [3:0] SUBSET_PP     = 4'h0;
  localparam logic [3:0] SUBSET_DC     = 4'h1;
  localparam logic [3:0] SUBSET_DT     = 4'h0;
  localparam logic [3:0] SUBSET_C      = 4'h0;
  // Register access command codes presented on cmd_code_i with cmd_valid_i.
  localparam logic [2:0] CMD_NONE      = 3'h0;
  localparam logic [2:0] CMD_SERIAL_POLL = 3'h1;
  localparam logic [2:0] CMD_STB_QUERY = 3'h2;
  localparam logic [2:0] CMD_ESR_QUERY = 3'h3;
  localparam logic [2:0] CMD_SRE_WRITE = 3'h4;
  localparam logic [2:0] CMD_SRE_QUERY = 3'h5;
  localparam logic [2:0] CMD_ESE_WRITE = 3'h6;
  localparam logic [2:0] CMD_ESE_QUERY = 3'h7;
endpackage

// ===== rtl/gssr_core.sv
// Status byte, event status and service request logic of a GPIB instrument.
`timescale 1ns/1ns

// Functional notes
// R1 - Request flag bit 6 sets on service request, clears on serial poll read.
// R2 - Status query returns master summary in bit 6: OR of status AND enable.
// R3 - Bit 5 is OR of event bits AND event enables, seen by both reads.
// R4 - Clear-status command resets status byte contents.
// R5 - Power-on enables 80h and 20h written beforehand give SRQ after power-up; the code reloads SRE_INIT and ESE_INIT at reset instead.
// R6 - Every power-up sets the power-on event bit 7.
// R7 - Event status query clears every event bit.
// R8 - Controller polls, tests bit 6, then bit 5, then reads event status.
// R9 - Supports SH1, AH1, SR1, RL1 and DC1 subsets.
// R10 - Talker subset T6, no talk-only.
// R11 - Listener subset L4, no listen-only.
// R12 - No parallel poll, device trigger ignored, never controller.
// R13 - Decode failure sets event bit 5, execution failure sets event bit 4.
// R14 - Status bits 7 and 4..0 read zero and feed no summary.
module gssr_core
  import gssr_pkg::*;
#(
  parameter logic [7:0] SRE_INIT = SRE_RESET,
  parameter logic [7:0] ESE_INIT = ESE_RESET
) (
  // Clock and power-on reset.
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // Command access from the message decoder.
  input  wire logic       cmd_valid_i,
  input  wire logic [2:0] cmd_code_i,
  input  wire logic [7:0] cmd_wdata_i,
  input  wire logic       clear_status_i,
  input  wire logic       device_trigger_i,
  // Error events from the message decoder and executor.
  input  wire logic       decode_error_i,
  input  wire logic       execution_error_i,
  // Read answer.
  output logic [7:0]      rdata_o,
  output logic            rvalid_o,
  // Bus service request line and status.
  output logic            srq_o,
  output logic [7:0]      status_summary_byte_o,
  // Advertised interface function subsets.
  output logic [39:0]     subsets_o,
  output logic            parallel_poll_en_o,
  output logic            controller_en_o
);

  logic [7:0] event_status_reg;
  logic [7:0] event_status_next;
  logic [7:0] event_enable_reg;
  logic [7:0] request_enable_mask_reg;
  logic       service_request_flag_reg;
  logic       service_request_flag_next;
  logic       srq_pending_reg;
  logic       power_on_seen_reg;
  logic [7:0] rdata_reg;
  logic       rvalid_reg;
  logic [7:0] status_summary_byte_reg;
  logic [39:0] subsets_reg;
  logic        parallel_poll_en_reg;
  logic        controller_en_reg;

  // The advertised capability word is fixed by the interface subsets.
  localparam logic [39:0] SUBSET_WORD = {SUBSET_SH, SUBSET_AH, SUBSET_T, SUBSET_L, SUBSET_SR,
                                         SUBSET_RL, SUBSET_PP, SUBSET_DC, SUBSET_DT, SUBSET_C}; // R9 R10 R11 R12

  wire do_poll      = cmd_valid_i && (cmd_code_i == CMD_SERIAL_POLL);
  wire do_stb_query = cmd_valid_i && (cmd_code_i == CMD_STB_QUERY);
  wire do_esr_query = cmd_valid_i && (cmd_code_i == CMD_ESR_QUERY);
  wire do_sre_write = cmd_valid_i && (cmd_code_i == CMD_SRE_WRITE);
  wire do_ese_write = cmd_valid_i && (cmd_code_i == CMD_ESE_WRITE);
  wire is_read      = cmd_valid_i && (cmd_code_i != CMD_SRE_WRITE)
                      && (cmd_code_i != CMD_ESE_WRITE) && (cmd_code_i != CMD_NONE);

  // Event events come from decoder strobes; power-on is a one-shot after reset release.
  wire [7:0] event_set;
  assign event_set[ESR_PON_BIT] = !power_on_seen_reg; // R6
  assign event_set[6]           = 1'b0;
  assign event_set[ESR_CME_BIT] = decode_error_i; // R13
  assign event_set[ESR_EXE_BIT] = execution_error_i; // R13
  assign event_set[3:0]         = 4'h0;

  // Sets win over the clearing read so a coincident error is not lost.
  assign event_status_next = (((do_esr_query || clear_status_i) ? BYTE_ZERO : event_status_reg)
                              | event_set) & ESR_USED_MASK; // R7

  wire event_summary = |(event_status_reg & event_enable_reg); // R3
  wire [7:0] status_bits = {1'b0, 1'b0, event_summary, 5'h00}; // R14
  wire summary_request = |(status_bits & request_enable_mask_reg & SRE_USED_MASK); // R2 R14
  wire master_summary_flag = summary_request;

  // The request flag rises on a new request and drops on a serial poll; a
  // new request in the poll cycle wins, and one still pending rearms only after the cause is renewed.
  wire new_request = summary_request && !srq_pending_reg; // R5
  assign service_request_flag_next = new_request ? 1'b1 :
                                     ((do_poll || clear_status_i) ? 1'b0 : service_request_flag_reg); // R1 R4

  wire [7:0] poll_byte  = {1'b0, service_request_flag_reg, event_summary, 5'h00}; // R1 R3 R14
  wire [7:0] query_byte = {1'b0, master_summary_flag, event_summary, 5'h00}; // R2 R3 R14

  wire [7:0] read_mux = do_poll                                      ? poll_byte :
                        do_stb_query                                 ? query_byte :
                        do_esr_query                                 ? event_status_reg :
                        (cmd_code_i == CMD_SRE_QUERY)                ? request_enable_mask_reg :
                        (cmd_code_i == CMD_ESE_QUERY)                ? event_enable_reg :
                                                                       BYTE_ZERO;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_status_reg <= BYTE_ZERO;
      power_on_seen_reg <= 1'b0;
    end else begin
      event_status_reg <= event_status_next; // R6 R7 R13
      power_on_seen_reg <= 1'b1;
    end
  end

  // Enable masks survive clear-status; power loss is modelled by resetn_i with
  // the mask defaults as parameters, as non-volatile storage lies outside.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      event_enable_reg <= ESE_INIT;
      request_enable_mask_reg <= SRE_INIT;
    end else begin
      if (do_ese_write) begin
        event_enable_reg <= cmd_wdata_i & ESR_USED_MASK;
      end
      if (do_sre_write) begin
        request_enable_mask_reg <= cmd_wdata_i & SRE_USED_MASK; // R14
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      service_request_flag_reg <= 1'b0;
      srq_pending_reg <= 1'b0;
    end else begin
      service_request_flag_reg <= service_request_flag_next; // R1 R5
      srq_pending_reg <= summary_request;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= BYTE_ZERO;
      rvalid_reg <= 1'b0;
      status_summary_byte_reg <= BYTE_ZERO;
    end else begin
      rdata_reg <= is_read ? read_mux : BYTE_ZERO;
      rvalid_reg <= is_read;
      status_summary_byte_reg <= query_byte;
    end
  end

  // Trigger is accepted and discarded; parallel poll and control stay off.
  wire unused_trigger = device_trigger_i; // R12

  // Constant capabilities still sit in flops so that every output is registered.
  // Reset loads the same values, so the word never shows a false subset.
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      subsets_reg          <= SUBSET_WORD;
      parallel_poll_en_reg <= 1'b0;
      controller_en_reg    <= 1'b0;
    end else begin
      subsets_reg          <= SUBSET_WORD; // R9 R10 R11
      parallel_poll_en_reg <= 1'b0; // R12
      controller_en_reg    <= 1'b0; // R12
    end
  end

  assign rdata_o  = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign srq_o    = service_request_flag_reg; // R1 R5
  assign status_summary_byte_o = status_summary_byte_reg;
  assign subsets_o = subsets_reg; // R9 R10 R11 R12
  assign parallel_poll_en_o = parallel_poll_en_reg; // R12
  assign controller_en_o    = controller_en_reg; // R12

endmodule

// ===== sim/gssr_core_sva.sv
// Port checker for the status and service request block.
`timescale 1ns/1ns
module gssr_core_sva
  import gssr_pkg::*;
(
  // Watched ports.
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        cmd_valid_i,
  input wire logic [2:0]  cmd_code_i,
  input wire logic [7:0]  cmd_wdata_i,
  input wire logic        clear_status_i,
  input wire logic [7:0]  rdata_o,
  input wire logic        rvalid_o,
  input wire logic        srq_o,
  input wire logic [7:0]  status_summary_byte_o,
  input wire logic [39:0] subsets_o,
  input wire logic        parallel_poll_en_o,
  input wire logic        controller_en_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire logic rd_cmd = cmd_valid_i && cmd_code_i inside {3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  wire logic poll   = cmd_valid_i && cmd_code_i == CMD_SERIAL_POLL;
  wire logic esr_rd = cmd_valid_i && cmd_code_i == CMD_ESR_QUERY;
  read_answer_a: assert property (rd_cmd |=> rvalid_o) else $error("read not answered");
  no_answer_a: assert property (!rd_cmd |=> !rvalid_o) else $error("answer without read");
  poll_clear_a: assert property (poll |=> !srq_o) else $error("flag kept after poll");
  poll_flag_a: assert property (poll && srq_o |=> rdata_o[6]) else $error("poll lost flag");
  poll_zero_a: assert property (poll |=> (rdata_o & 8'h9F) == 8'h00) else $error("unused bit set");
  stb_zero_a: assert property ((status_summary_byte_o & 8'h9F) == 8'h00) else $error("unused bit set");
  clear_stat_a: assert property (clear_status_i |=> !srq_o) else $error("flag kept after clear");
  esr_twice_a: assert property (esr_rd ##2 esr_rd |=> rdata_o == 8'h00) else $error("event not cleared");
  sre_mask_a: assert property ((cmd_valid_i && cmd_code_i == CMD_SRE_WRITE) ##2 (cmd_valid_i && cmd_code_i == CMD_SRE_QUERY)
    |=> rdata_o == ($past(cmd_wdata_i, 3) & SRE_USED_MASK)) else $error("enable mask wrong");
  subset_set_a: assert property (!parallel_poll_en_o && !controller_en_o && subsets_o == {SUBSET_SH, SUBSET_AH,
    SUBSET_T, SUBSET_L, SUBSET_SR, SUBSET_RL, SUBSET_PP, SUBSET_DC, SUBSET_DT, SUBSET_C}) else $error("subset wrong");
  cover property (esr_rd ##2 esr_rd);
  cover property ($rose(srq_o));
  cover property (clear_status_i && srq_o);
endmodule

bind gssr_core gssr_core_sva chk (.*);

// ===== sim/gssr_ctrl_model.sv
// Bus controller model that sends commands and services a request.
`timescale 1ns/1ns
module gssr_ctrl_model
  import gssr_pkg::*;
(
  // Clock and answer from the device.
  input  wire logic       clock_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  // Command to the device.
  output logic            cmd_valid_o = 1'b0,
  output logic [2:0]      cmd_code_o = CMD_NONE,
  output logic [7:0]      cmd_wdata_o = 8'h00
);
  // Call just after an edge; released fields show the inverse so stale data cannot pass.
  task automatic xfer(input logic [2:0] code, input logic [7:0] data, output logic [7:0] rd);
    cmd_valid_o <= 1'b1;
    cmd_code_o  <= code;
    cmd_wdata_o <= data;
    @(posedge clock_i) cmd_valid_o <= 1'b0;
    cmd_code_o  <= ~code;
    cmd_wdata_o <= ~data;
    @(posedge clock_i) rd = rvalid_i ? rdata_i : 8'hXX;
  endtask
  task automatic service(output logic [7:0] stb, output logic [7:0] esr);
    esr = 8'h00;
    xfer(CMD_SERIAL_POLL, 8'h00, stb);
    if (stb[6] && stb[5]) xfer(CMD_ESR_QUERY, 8'h00, esr);
  endtask
endmodule

// ===== sim/gssr_core_tb_top.sv
// Self-checking testbench for the status and service request block.
`timescale 1ns/1ns
module gssr_core_tb_top;
  import gssr_pkg::*;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic       clear_i = 1'b0;
  logic       trig_i = 1'b0;
  logic       dec_i = 1'b0;
  logic       exe_i = 1'b0;
  logic       cmd_valid_i, rvalid_o, srq_o;
  logic [2:0] cmd_code_i;
  logic [7:0] cmd_wdata_i, rdata_o, stb, esr, rd;
  logic [7:0] ssb_o;
  logic [39:0] subs_o;
  logic       pp_o;
  logic       ctl_en_o;
  int         failures = 0;
  int         compares = 0;
  always #25 clock_i = ~clock_i;
  gssr_ctrl_model ctl (.clock_i(clock_i), .rdata_i(rdata_o), .rvalid_i(rvalid_o),
    .cmd_valid_o(cmd_valid_i), .cmd_code_o(cmd_code_i), .cmd_wdata_o(cmd_wdata_i));
  gssr_core #(.SRE_INIT(8'h20), .ESE_INIT(8'h80)) uut (.clock_i(clock_i), .resetn_i(resetn_i),
    .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_wdata_i(cmd_wdata_i), .clear_status_i(clear_i),
    .device_trigger_i(trig_i), .decode_error_i(dec_i), .execution_error_i(exe_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .srq_o(srq_o), .status_summary_byte_o(ssb_o), .subsets_o(subs_o),
    .parallel_poll_en_o(pp_o), .controller_en_o(ctl_en_o));
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_masks();
    ctl.xfer(CMD_SRE_WRITE, 8'hFF, rd);
    ctl.xfer(CMD_SRE_QUERY, 8'h00, rd);
    chk("sre", rd, 8'h20);
    ctl.xfer(CMD_ESE_WRITE, 8'hFF, rd);
    ctl.xfer(CMD_ESE_QUERY, 8'h00, rd);
    chk("ese", rd, 8'hB0);
    ctl.xfer(CMD_NONE, 8'hFF, rd);
    chk("sub_hand", subs_o[39:32], 8'h11);
    chk("sub_talk", subs_o[31:24], 8'h64);
    chk("sub_srrl", subs_o[23:16], 8'h11);
    chk("sub_ppdc", subs_o[15:8], 8'h01);
    chk("sub_dtc", subs_o[7:0], 8'h00);
    chk("no_ctrl", {6'h00, pp_o, ctl_en_o}, 8'h00);
  endtask
  // A mid-run reset stands in for a power cycle of the instrument.
  task automatic t_power();
    ctl.xfer(CMD_ESE_WRITE, 8'h80, rd);
    ctl.xfer(CMD_SRE_WRITE, 8'h20, rd);
    resetn_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    chk("srq_on", {7'h00, srq_o}, 8'h01);
    ctl.service(stb, esr);
    chk("poll", stb, 8'h60);
    chk("srq_off", {7'h00, srq_o}, 8'h00);
    chk("esr_pon", esr, 8'h80);
    ctl.xfer(CMD_ESR_QUERY, 8'h00, rd);
    chk("esr_again", rd, 8'h00);
    ctl.xfer(CMD_SRE_QUERY, 8'h00, rd);
    chk("sre_pon", rd, 8'h20);
    ctl.xfer(CMD_ESE_QUERY, 8'h00, rd);
    chk("ese_pon", rd, 8'h80);
  endtask
  task automatic t_errors();
    ctl.xfer(CMD_ESE_WRITE, 8'h10, rd);
    @(posedge clock_i) dec_i <= 1'b1;
    trig_i <= 1'b1;
    @(posedge clock_i) dec_i <= 1'b0;
    trig_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    ctl.xfer(CMD_STB_QUERY, 8'h00, rd);
    chk("stb_masked", rd, 8'h00);
    chk("stb_view0", ssb_o, 8'h00);
    @(posedge clock_i) exe_i <= 1'b1;
    @(posedge clock_i) exe_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    ctl.xfer(CMD_STB_QUERY, 8'h00, rd);
    chk("stb_sum", rd, 8'h60);
    chk("stb_view", ssb_o, 8'h60);
    ctl.xfer(CMD_ESR_QUERY, 8'h00, rd);
    chk("esr_err", rd, 8'h30);
    // Poll here so that the next check sees a request raised afresh.
    ctl.xfer(CMD_SERIAL_POLL, 8'h00, rd);
    chk("poll_err", rd, 8'h40);
    chk("srq_poll", {7'h00, srq_o}, 8'h00);
    @(posedge clock_i) exe_i <= 1'b1;
    @(posedge clock_i) exe_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk("srq_exe", {7'h00, srq_o}, 8'h01);
    clear_i <= 1'b1;
    @(posedge clock_i) clear_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    chk("srq_cls", {7'h00, srq_o}, 8'h00);
    ctl.xfer(CMD_ESR_QUERY, 8'h00, rd);
    chk("esr_cls", rd, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    t_masks();
    t_power();
    t_errors();
    give_verdict();
  end
  initial begin
    #(3000 * 50);
    failures++;
    give_verdict();
  end
endmodule
